/* core/rci_top.sv */
// reset cause flags and per-cause register initialisation with axi4-lite access
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - undefined registers are unknown after power-on and kept by every other reset
// - watchdog wake-up leaves most registers untouched, execution resumes
// - power-on: pc zero, reset, timeout, power-down flags set; others cleared
// - brown-out: pc zero, reset, timeout, power-down flags set; brown-out flag cleared
// - reset instruction: pc zero, clears only the reset-instruction flag
// - master clear in idle or sleep: pc zero, set timeout, clear power-down
// - master clear at full power changes no flag; in run mode sets timeout
// - watchdog at full power or run: pc zero, clear timeout flag
// - watchdog in idle or sleep: wake at pc plus 2, clear timeout and power-down
// - interrupt wake clears power-down; pc plus 2 or a priority vector
// - stack full with error reset enabled: pc zero, set full flag
// - stack underflow with error reset enabled: pc zero, set underflow flag
// - underflow with error reset disabled: no reset, set underflow flag
// - soft brown-out enable: 1 on power-on when config 01, else kept or 0
// - defined registers take fixed values (irqctl bit 0 kept by other resets); wake-ups keep them, except a vectored interrupt wake loads the return stack
// - one init class for power-on/brown-out, one for other resets, one for wake-ups
// - brown-out flag cleared on every brown-out or power-on event
module rci_top (
  input wire logic aclk, // core clock
  input wire logic aresetn, // synchronous reset, active low
  input wire rci_pkg::rci_src_s src, // reset and wake source pulses
  input wire rci_pkg::rci_pm_e pm_mode, // power-managed mode at the event
  input wire logic [1:0] brownout_config, // configuration bits
  input wire logic stack_error_reset_enable, // stack errors reset the core
  input wire logic [20:0] cur_pc, // current program counter
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic core_restart, // pulse: load pc_load and run
  output logic [20:0] pc_load, // program counter to load
  output rci_pkg::rci_intc_s intc, // interrupt control registers
  output logic irq // level interrupt
);
  import rci_pkg::*;

  logic [9:0] cause_r;
  logic swbo_en_r;
  logic [20:0] pc_r;
  logic restart_r;
  logic [20:0] rstack_r;
  logic [20:0] tblptr_r;
  logic [31:0] keep_r;
  rci_intc_s intc_r;
  logic [RCI_NEV-1:0] ev_stat_r;
  logic [RCI_NEV-1:0] ev_mask_r;
  logic irq_r;
  logic [9:0] cause_nxt;
  logic swbo_en_nxt;
  logic [20:0] pc_nxt;
  logic do_reset;
  logic do_full;
  logic do_wake;
  logic idle_sl;
  logic [RCI_NEV-1:0] ev;
  logic wr_go;
  logic rd_go;
  logic wr_hit;
  logic [31:0] rd_val;
  logic rd_hit;
  logic [31:0] aw_addr_r;
  logic aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_have_r;
  logic [31:0] wmask;

  assign idle_sl = (pm_mode == RCI_PM_IDLE) || (pm_mode == RCI_PM_SLEEP);
  // full-class resets (power-on, brown-out) and partial-class resets
  assign do_full = src.por | src.brownout;
  assign do_reset = do_full | src.mclear | src.rst_instr
    | (src.wdt & ~idle_sl)
    | (stack_error_reset_enable & (src.stk_full | src.stk_unf));
  assign do_wake = ~do_reset & ((src.wdt & idle_sl) | src.irq_wake);

  // cause flag update, priority power-on > brown-out > others
  always_comb begin
    cause_nxt = cause_r;
    swbo_en_nxt = swbo_en_r;
    pc_nxt = pc_r;
    if (src.por) begin
      cause_nxt[RCI_B_RSTI] = 1'b1;
      cause_nxt[RCI_B_WDTO] = 1'b1;
      cause_nxt[RCI_B_PWRDN] = 1'b1;
      cause_nxt[RCI_B_POR] = 1'b0;
      cause_nxt[RCI_B_BRNO] = 1'b0;
      cause_nxt[RCI_B_SFULL] = 1'b0;
      cause_nxt[RCI_B_SUNDR] = 1'b0;
      swbo_en_nxt = (brownout_config == RCI_BRNO_SOFT);
      pc_nxt = RCI_PC_RESET;
    end else if (src.brownout) begin
      cause_nxt[RCI_B_RSTI] = 1'b1;
      cause_nxt[RCI_B_WDTO] = 1'b1;
      cause_nxt[RCI_B_PWRDN] = 1'b1;
      cause_nxt[RCI_B_BRNO] = 1'b0;
      swbo_en_nxt = (brownout_config == RCI_BRNO_SOFT) & swbo_en_r;
      pc_nxt = RCI_PC_RESET;
    end else begin
      if (src.rst_instr) begin
        cause_nxt[RCI_B_RSTI] = 1'b0;
      end
      if (src.mclear && idle_sl) begin
        cause_nxt[RCI_B_WDTO] = 1'b1;
        cause_nxt[RCI_B_PWRDN] = 1'b0;
      end else if (src.mclear && pm_mode == RCI_PM_RUN) begin
        cause_nxt[RCI_B_WDTO] = 1'b1;
      end
      if (src.wdt && !idle_sl) begin
        cause_nxt[RCI_B_WDTO] = 1'b0;
      end
      if (src.stk_full && stack_error_reset_enable) begin
        cause_nxt[RCI_B_SFULL] = 1'b1;
      end
      if (src.stk_unf) begin
        cause_nxt[RCI_B_SUNDR] = 1'b1;
      end
      if (do_reset) begin
        pc_nxt = RCI_PC_RESET;
        swbo_en_nxt = (brownout_config == RCI_BRNO_SOFT) & swbo_en_r;
      end else if (src.wdt && idle_sl) begin
        cause_nxt[RCI_B_WDTO] = 1'b0;
        cause_nxt[RCI_B_PWRDN] = 1'b0;
        pc_nxt = 21'(cur_pc + RCI_PC_STEP);
      end else if (src.irq_wake) begin
        cause_nxt[RCI_B_PWRDN] = 1'b0;
        if (intc_r.irqctl[7]) begin
          pc_nxt = RCI_VEC_HIGH;
        end else if (intc_r.irqctl[6]) begin
          pc_nxt = RCI_VEC_LOW;
        end else begin
          pc_nxt = 21'(cur_pc + RCI_PC_STEP);
        end
      end
    end
  end

  // axi write channel capture
  assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign wr_hit = aw_addr_r[31:6] == 26'h0 && aw_addr_r[1:0] == 2'h0
    && aw_addr_r[5:0] <= RCI_OFF_KEEP[5:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 32'h0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_have_r & ~s_axi_awready & s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= ~w_have_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RCI_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RCI_RESP_OKAY : RCI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // cause flags: power-on flag is software-set, soft brown-out enable software-writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_r <= RCI_CAUSE_INIT;
      swbo_en_r <= 1'b0;
    end else begin
      cause_r <= cause_nxt;
      swbo_en_r <= swbo_en_nxt;
      if (wr_go && aw_addr_r == RCI_OFF_CAUSE && w_strb_r[0] && !do_reset) begin
        cause_r[RCI_B_POR] <= w_data_r[RCI_B_POR];
      end
      if (wr_go && aw_addr_r == RCI_OFF_CTRL && w_strb_r[0] && !do_reset) begin
        swbo_en_r <= (brownout_config == RCI_BRNO_SOFT) & w_data_r[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_r <= RCI_PC_RESET;
      restart_r <= 1'b0;
    end else begin
      pc_r <= pc_nxt;
      restart_r <= do_reset | do_wake;
    end
  end

  // defined-state registers: reset-class values, wake-ups keep them except rstack_r on a vectored wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rstack_r <= RCI_RSTACK_INIT;
      tblptr_r <= RCI_TBLPTR_INIT;
      intc_r <= '{RCI_IRQCTL_INIT, RCI_IRQCTL2_INIT, RCI_IRQCTL3_INIT};
    end else if (do_reset) begin
      rstack_r <= RCI_RSTACK_INIT;
      tblptr_r <= RCI_TBLPTR_INIT;
      intc_r.irqctl <= {RCI_IRQCTL_INIT[7:1], do_full ? 1'b0 : intc_r.irqctl[0]};
      intc_r.irqctl2 <= RCI_IRQCTL2_INIT;
      intc_r.irqctl3 <= RCI_IRQCTL3_INIT;
    end else if (do_wake && src.irq_wake && (intc_r.irqctl[7] || intc_r.irqctl[6])) begin
      rstack_r <= cur_pc; // return address pushed on vectored wake
    end else if (wr_go && aw_addr_r == RCI_OFF_INIT) begin
      intc_r <= (intc_r & ~wmask[23:0]) | (w_data_r[23:0] & wmask[23:0]);
    end else if (wr_go && aw_addr_r == RCI_OFF_TBLPTR) begin
      tblptr_r <= (tblptr_r & ~wmask[20:0]) | (w_data_r[20:0] & wmask[20:0]);
    end
  end

  // undefined-state register: no reset term, kept across all resets
  always_ff @(posedge aclk) begin
    if (wr_go && aw_addr_r == RCI_OFF_KEEP) begin
      keep_r <= (keep_r & ~wmask) | (w_data_r & wmask);
    end
  end

  // sticky event status, write one to clear, set wins
  assign ev = {src.irq_wake, src.stk_unf, src.stk_full, src.rst_instr, src.wdt,
    src.mclear, src.brownout, src.por, do_wake, do_reset};
  genvar gi;
  generate
    for (gi = 0; gi < RCI_NEV; gi++) begin : g_ev
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ev_stat_r[gi] <= 1'b0;
        end else if (ev[gi]) begin
          ev_stat_r[gi] <= 1'b1;
        end else if (wr_go && aw_addr_r == RCI_OFF_IRQ_STAT && wmask[gi] && w_data_r[gi]) begin
          ev_stat_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_mask_r <= '0;
      irq_r <= 1'b0;
    end else begin
      if (wr_go && aw_addr_r == RCI_OFF_IRQ_MASK) begin
        ev_mask_r <= (ev_mask_r & ~wmask[RCI_NEV-1:0]) | (w_data_r[RCI_NEV-1:0] & wmask[RCI_NEV-1:0]);
      end
      irq_r <= |(ev_stat_r & ev_mask_r);
    end
  end

  // read channel
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      RCI_OFF_CAUSE: rd_val = {22'h0, cause_r};
      RCI_OFF_CTRL: rd_val = {31'h0, swbo_en_r};
      RCI_OFF_IRQ_STAT: rd_val = {22'h0, ev_stat_r};
      RCI_OFF_IRQ_MASK: rd_val = {22'h0, ev_mask_r};
      RCI_OFF_PC: rd_val = {11'h0, pc_r};
      RCI_OFF_INIT: rd_val = {8'h0, intc_r};
      RCI_OFF_RSTACK: rd_val = {11'h0, rstack_r};
      RCI_OFF_TBLPTR: rd_val = {11'h0, tblptr_r};
      RCI_OFF_KEEP: rd_val = keep_r;
      default: begin
        rd_val = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end
  assign rd_go = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RCI_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? RCI_RESP_OKAY : RCI_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_restart <= 1'b0;
      pc_load <= RCI_PC_RESET;
      intc <= '{RCI_IRQCTL_INIT, RCI_IRQCTL2_INIT, RCI_IRQCTL3_INIT};
      irq <= 1'b0;
    end else begin
      core_restart <= restart_r;
      pc_load <= pc_r;
      intc <= intc_r;
      irq <= irq_r;
    end
  end

  a_por_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    src.por |=> cause_r[RCI_B_RSTI] && cause_r[RCI_B_WDTO] && cause_r[RCI_B_PWRDN]
      && !cause_r[RCI_B_POR] && !cause_r[RCI_B_BRNO] && !cause_r[RCI_B_SFULL]
      && !cause_r[RCI_B_SUNDR])
    else $error("power-on flags wrong");
  a_bor_keeps_por: assert property (@(posedge aclk) disable iff (!aresetn)
    src.brownout && !src.por |=> !cause_r[RCI_B_BRNO]
      && cause_r[RCI_B_POR] == $past(cause_r[RCI_B_POR]))
    else $error("brown-out flags wrong");
  a_ri_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    src.rst_instr && !src.por && !src.brownout |=> !cause_r[RCI_B_RSTI] && pc_r == RCI_PC_RESET)
    else $error("reset instruction flag wrong");
  a_mclear_sleep: assert property (@(posedge aclk) disable iff (!aresetn)
    src == 8'h20 && idle_sl |=> cause_r[RCI_B_WDTO] && !cause_r[RCI_B_PWRDN])
    else $error("master clear in sleep wrong");
  a_mclear_full: assert property (@(posedge aclk) disable iff (!aresetn)
    src == 8'h20 && pm_mode == RCI_PM_FULL |=> $stable(cause_r))
    else $error("master clear at full power changed flags");
  a_wdt_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    src == 8'h10 && !idle_sl |=> !cause_r[RCI_B_WDTO] ##1 pc_load == RCI_PC_RESET)
    else $error("watchdog reset wrong");
  a_wdt_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    src == 8'h10 && idle_sl |=> pc_r == 21'($past(cur_pc) + RCI_PC_STEP)
      && !cause_r[RCI_B_PWRDN] && !cause_r[RCI_B_WDTO])
    else $error("watchdog wake wrong");
  a_unf_noreset: assert property (@(posedge aclk) disable iff (!aresetn)
    src == 8'h02 && !stack_error_reset_enable |=> cause_r[RCI_B_SUNDR] && !restart_r)
    else $error("underflow without reset wrong");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    |(ev_stat_r & ev_mask_r) |=> ##1 irq)
    else $error("interrupt not raised");
  c_por: cover property (@(posedge aclk) src.por ##2 core_restart);
  c_wake: cover property (@(posedge aclk) do_wake && src.irq_wake);
  c_stack: cover property (@(posedge aclk) src.stk_full && stack_error_reset_enable);
endmodule : rci_top
`default_nettype wire

/* core/rci_pkg.sv */
// package for the reset cause and register init block
package rci_pkg;
  localparam logic [31:0] RCI_OFF_CAUSE = 32'h0000_0000;
  localparam logic [31:0] RCI_OFF_CTRL = 32'h0000_0004;
  localparam logic [31:0] RCI_OFF_IRQ_STAT = 32'h0000_0008;
  localparam logic [31:0] RCI_OFF_IRQ_MASK = 32'h0000_000c;
  localparam logic [31:0] RCI_OFF_PC = 32'h0000_0010;
  localparam logic [31:0] RCI_OFF_INIT = 32'h0000_0014;
  localparam logic [31:0] RCI_OFF_RSTACK = 32'h0000_0018;
  localparam logic [31:0] RCI_OFF_TBLPTR = 32'h0000_001c;
  localparam logic [31:0] RCI_OFF_KEEP = 32'h0000_0020;
  localparam int RCI_B_SWBO_EN = 6;
  localparam int RCI_B_RSTI = 4;
  localparam int RCI_B_WDTO = 3;
  localparam int RCI_B_PWRDN = 2;
  localparam int RCI_B_POR = 1;
  localparam int RCI_B_BRNO = 0;
  localparam int RCI_B_SFULL = 8;
  localparam int RCI_B_SUNDR = 9;
  localparam logic [9:0] RCI_CAUSE_INIT = 10'h01e;
  localparam logic [20:0] RCI_PC_RESET = 21'h00_0000;
  localparam logic [20:0] RCI_VEC_HIGH = 21'h00_0008;
  localparam logic [20:0] RCI_VEC_LOW = 21'h00_0018;
  localparam logic [20:0] RCI_PC_STEP = 21'h00_0002;
  localparam logic [1:0] RCI_BRNO_SOFT = 2'h1;
  localparam logic [7:0] RCI_IRQCTL_INIT = 8'h00;
  localparam logic [7:0] RCI_IRQCTL2_INIT = 8'hff;
  localparam logic [7:0] RCI_IRQCTL3_INIT = 8'hc0;
  localparam logic [20:0] RCI_RSTACK_INIT = 21'h00_0000;
  localparam logic [20:0] RCI_TBLPTR_INIT = 21'h00_0000;
  localparam logic [31:0] RCI_KEEP_INIT = 32'h0000_0000;
  localparam logic [1:0] RCI_RESP_OKAY = 2'h0;
  localparam logic [1:0] RCI_RESP_SLVERR = 2'h2;
  localparam int RCI_NEV = 10;
  typedef enum logic [1:0] {RCI_PM_FULL, RCI_PM_RUN, RCI_PM_IDLE, RCI_PM_SLEEP} rci_pm_e;
  // reset and wake sources, one-cycle pulses from core logic
  typedef struct packed {
    logic por;
    logic brownout;
    logic mclear;
    logic wdt;
    logic rst_instr;
    logic stk_full;
    logic stk_unf;
    logic irq_wake;
  } rci_src_s;
  typedef struct packed {
    logic [7:0] irqctl;
    logic [7:0] irqctl2;
    logic [7:0] irqctl3;
  } rci_intc_s;
endpackage : rci_pkg

/* tb/tb.sv */
// self-checking bench for the reset cause and register init block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rci_pkg::*;
  localparam logic [7:0] S_POR = 8'h80, S_BRN = 8'h40, S_MCL = 8'h20, S_WDT = 8'h10;
  localparam logic [7:0] S_RSI = 8'h08, S_SF = 8'h04, S_SU = 8'h02, S_IW = 8'h01;
  localparam logic [31:0] NOCHK = 32'hffff_ffff;
  logic aclk, aresetn, sere, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, core_restart, irq;
  rci_src_s src;
  rci_pm_e pm_mode;
  rci_intc_s intc;
  logic [1:0] bocfg, bresp, rresp;
  logic [20:0] cur_pc, pc_load;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  int error_cnt, num_checks;
  rci_top u_dut (.aclk(aclk), .aresetn(aresetn), .src(src), .pm_mode(pm_mode),
    .brownout_config(bocfg), .stack_error_reset_enable(sere), .cur_pc(cur_pc),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .core_restart(core_restart), .pc_load(pc_load), .intc(intc), .irq(irq));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic hang(input string what);
    error_cnt++;
    $display("CHECK FAILED %s expected answer seen timeout", what);
    stop_test();
  endtask : hang
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic ga, gw;
    n = 0; ga = 0; gw = 0; r = '0;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (!ga && awready === 1'b1) begin ga = 1; awvalid <= 1'b0; end
      if (!gw && wready === 1'b1) begin gw = 1; wvalid <= 1'b0; end
      if (ga && gw && bvalid === 1'b1) begin r = bresp; break; end
      if (n > 40) hang("write");
    end
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ga;
    n = 0; ga = 0; d = '0; r = '0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (!ga && arready === 1'b1) begin ga = 1; arvalid <= 1'b0; end
      if (ga && rvalid === 1'b1) begin d = rdata; r = rresp; break; end
      if (n > 40) hang("read");
    end
  endtask : rd
  // one source pulse, then restart, load address and cause flags are judged
  task automatic ev(input logic [7:0] s, input rci_pm_e m, input logic rs,
                    input logic [20:0] pc, input logic [31:0] cz);
    logic seen;
    logic [20:0] got;
    logic [31:0] d;
    logic [1:0] r;
    seen = 0; got = '0;
    src <= rci_src_s'(s); pm_mode <= m;
    @(posedge aclk);
    src <= rci_src_s'(8'h00);
    repeat (5) begin
      @(posedge aclk);
      if (core_restart === 1'b1) begin seen = 1; got = pc_load; end
    end
    chk("restart", {31'h0, seen}, {31'h0, rs});
    if (rs) chk("pc_load", {11'h0, got}, {11'h0, pc});
    if (cz !== NOCHK) begin
      rd(RCI_OFF_CAUSE, d, r);
      chk("cause", d & 32'h0000_031f, cz);
    end
  endtask : ev
  task automatic t_causes();
    logic [31:0] d;
    logic [1:0] r;
    bocfg <= 2'h1; sere <= 1'b0; cur_pc <= 21'h00_0100;
    ev(S_POR, RCI_PM_FULL, 1, RCI_PC_RESET, 32'h01c);
    rd(RCI_OFF_CTRL, d, r);
    chk("swbo_en", d & 32'h1, 32'h1);
    chk("intc", {8'h0, intc}, 32'h00ff_c0);
    rd(RCI_OFF_RSTACK, d, r);
    chk("rstack", d, 32'h0);
    rd(RCI_OFF_TBLPTR, d, r);
    chk("tblptr", d, 32'h0);
    wr(RCI_OFF_CAUSE, 32'h2, r);
    ev(S_RSI, RCI_PM_FULL, 1, RCI_PC_RESET, 32'h00e);
    ev(S_WDT, RCI_PM_FULL, 1, RCI_PC_RESET, 32'h006);
    ev(S_MCL, RCI_PM_RUN, 1, RCI_PC_RESET, 32'h00e);
    ev(S_MCL, RCI_PM_FULL, 1, RCI_PC_RESET, 32'h00e);
    ev(S_WDT, RCI_PM_RUN, 1, RCI_PC_RESET, 32'h006);
    ev(S_WDT, RCI_PM_SLEEP, 1, 21'h00_0102, 32'h002);
    ev(S_MCL, RCI_PM_IDLE, 1, RCI_PC_RESET, 32'h00a);
    ev(S_BRN, RCI_PM_FULL, 1, RCI_PC_RESET, 32'h01e);
    rd(RCI_OFF_CTRL, d, r);
    chk("swbo_en_kept", d & 32'h1, 32'h1);
    $display("test causes done");
  endtask : t_causes
  task automatic t_wake();
    logic [31:0] d;
    logic [1:0] r;
    ev(S_IW, RCI_PM_SLEEP, 1, 21'h00_0102, 32'h01a);
    wr(RCI_OFF_INIT, 32'h0080_ffc0, r);
    ev(S_IW, RCI_PM_IDLE, 1, RCI_VEC_HIGH, 32'h01a);
    chk("intc_wake", {8'h0, intc}, 32'h0080_ffc0);
    rd(RCI_OFF_RSTACK, d, r);
    chk("rstack_push", d, 32'h0000_0100);
    wr(RCI_OFF_INIT, 32'h0040_ffc0, r);
    ev(S_IW, RCI_PM_SLEEP, 1, RCI_VEC_LOW, 32'h01a);
    ev(S_MCL, RCI_PM_FULL, 1, RCI_PC_RESET, 32'h01a);
    chk("intc_mclear", {8'h0, intc}, 32'h00ff_c0);
    rd(RCI_OFF_RSTACK, d, r);
    chk("rstack_clear", d, 32'h0);
    $display("test wake done");
  endtask : t_wake
  task automatic t_stack();
    logic [31:0] d;
    logic [1:0] r;
    ev(S_SU, RCI_PM_FULL, 0, RCI_PC_RESET, 32'h21a);
    ev(S_POR, RCI_PM_FULL, 1, RCI_PC_RESET, 32'h01c);
    wr(RCI_OFF_KEEP, 32'h1234_5678, r);
    sere <= 1'b1;
    ev(S_SF, RCI_PM_FULL, 1, RCI_PC_RESET, 32'h11c);
    ev(S_SU, RCI_PM_FULL, 1, RCI_PC_RESET, 32'h31c);
    ev(S_RSI, RCI_PM_FULL, 1, RCI_PC_RESET, 32'h30c);
    ev(S_BRN | S_RSI, RCI_PM_FULL, 1, RCI_PC_RESET, 32'h31c);
    ev(S_WDT, RCI_PM_SLEEP, 1, 21'h00_0102, 32'h310);
    rd(RCI_OFF_KEEP, d, r);
    chk("keep", d, 32'h1234_5678);
    ev(S_POR | S_BRN, RCI_PM_FULL, 1, RCI_PC_RESET, 32'h01c);
    $display("test stack done");
  endtask : t_stack
  task automatic t_swbo_en();
    logic [31:0] d;
    logic [1:0] r;
    for (int c = 0; c < 4; c++) begin
      bocfg <= 2'(c);
      ev(S_POR, RCI_PM_FULL, 1, RCI_PC_RESET, NOCHK);
      rd(RCI_OFF_CTRL, d, r);
      chk("swbo_en_cfg", d & 32'h1, {31'h0, (c == 1)});
    end
    $display("test soft brown-out enable done");
  endtask : t_swbo_en
  task automatic t_irq_bus();
    logic [31:0] d;
    logic [1:0] r;
    logic a;
    wr(RCI_OFF_IRQ_STAT, 32'h3ff, r);
    ev(S_MCL, RCI_PM_FULL, 1, RCI_PC_RESET, NOCHK);
    rd(RCI_OFF_IRQ_STAT, d, r);
    chk("irq_stat", d & 32'h3ff, 32'h011);
    wr(RCI_OFF_IRQ_MASK, 32'h0, r);
    repeat (2) @(posedge aclk);
    a = irq;
    wr(RCI_OFF_IRQ_MASK, 32'h3ff, r);
    repeat (2) @(posedge aclk);
    chk("irq_masked", {31'h0, a}, 32'h0);
    chk("irq_mask", {31'h0, irq}, 32'h1);
    wr(RCI_OFF_IRQ_STAT, 32'h3ff, r);
    repeat (2) @(posedge aclk);
    chk("irq_clear", {31'h0, irq}, 32'h0);
    rd(RCI_OFF_IRQ_STAT, d, r);
    chk("irq_stat_clr", d & 32'h3ff, 32'h0);
    wr(32'h0000_0040, 32'h5, r);
    chk("wr_unmapped", {30'h0, r}, {30'h0, RCI_RESP_SLVERR});
    rd(32'h0000_0040, d, r);
    chk("rd_unmapped", {30'h0, r}, {30'h0, RCI_RESP_SLVERR});
    chk("rd_unmapped_data", d, 32'h0);
    wstrb <= 4'h0;
    wr(RCI_OFF_IRQ_MASK, 32'h0, r);
    wstrb <= 4'hf;
    rd(RCI_OFF_IRQ_MASK, d, r);
    chk("mask_no_strobe", d & 32'h3ff, 32'h3ff);
    $display("test irq and bus done");
  endtask : t_irq_bus
  initial begin
    aresetn = 1'b0; src = rci_src_s'(8'h00); pm_mode = RCI_PM_FULL; bocfg = 2'h0;
    sere = 1'b0; cur_pc = '0; awaddr = '0; wdata = '0; araddr = '0; wstrb = 4'hf;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    error_cnt = 0; num_checks = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_causes();
    t_wake();
    t_stack();
    t_swbo_en();
    t_irq_bus();
    stop_test();
  end
endmodule : tb
`default_nettype wire
